/* File: core/snv_pkg.sv */
// shared constants and types for the two-wire nonvolatile memory link
package snv_pkg;

	// ************************************************************
	// memory geometry
	// ************************************************************
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 15;
	localparam int MEM_DEPTH = 1 << ADDR_W;
	// the high address byte carries one bit the decoder ignores
	localparam int ADDR_HI_USED = ADDR_W - BYTE_W;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

	// ************************************************************
	// slave address byte layout
	// ************************************************************
	localparam int DIR_BIT = 0;
	localparam int SEL_LSB = 1;
	localparam int TYPE_LSB = 4;
	// device type code: value is arbitrary, the DEV_TYPE parameter may override it
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// ************************************************************
	// timing of the master's clock divider
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCL_PERIOD_NS = 10000;
	// four quarter phases per line clock, rounded down
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	// ************************************************************
	// state and command encodings
	// ************************************************************
	typedef enum logic [7:0] {
		st_idle = 8'h01,
		st_addr = 8'h02,
		st_ack = 8'h04,
		st_mhi = 8'h08,
		st_mlo = 8'h10,
		st_wdata = 8'h20,
		st_rdata = 8'h40,
		st_rack = 8'h80
	} snv_slv_state_t;

	typedef enum logic [1:0] {
		mst_idle = 2'h1,
		mst_run = 2'h2
	} snv_mst_state_t;

	typedef enum logic [1:0] {
		op_start = 2'h0,
		op_stop = 2'h1,
		op_write = 2'h2,
		op_read = 2'h3
	} snv_op_t;

endpackage // snv_pkg

/* File: core/snv_link_if.sv */
// carrier for the two-wire link between bus master and memory slave
`timescale 1ns/1ns
interface snv_link_if;
	// clock line, made by the master alone
	logic scl;
	// open-drain data line, one driver pair per end
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	// resolved line level
	logic sda;

	// wired-and with pull-up: any enabled low driver wins
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport master (
		output scl,
		output m_sda_o,
		output m_sda_oe,
		input sda
	);
	modport slave (
		input scl,
		output s_sda_o,
		output s_sda_oe,
		input sda
	);
endinterface // snv_link_if

/* File: core/snv_slave.sv */
// memory end of the two-wire link: protocol engine and byte array
`timescale 1ns/1ns

// ************************************************************
// slave engine, clocked by the link clock
// ************************************************************
module snv_slave #(
	parameter int ADDR_W = snv_pkg::ADDR_W,
	parameter logic [3:0] DEV_TYPE = snv_pkg::DEV_TYPE
) (
	// power-on reset
	input wire logic nrst,
	// two-wire link
	snv_link_if.slave link,
	// static pins of the device
	input wire logic [2:0] chip_select_pins,
	input wire logic write_protect
);

	// ************************************************************
	// declarations
	// ************************************************************
	snv_pkg::snv_slv_state_t state;
	snv_pkg::snv_slv_state_t next_state;
	snv_pkg::snv_slv_state_t ret_state;
	snv_pkg::snv_slv_state_t next_ret_state;
	logic start_tgl;
	logic stop_tgl;
	logic start_seen;
	logic stop_seen;
	logic start_ev;
	logic stop_ev;
	logic sda_smp;
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic wp;
	logic [2:0] sel;
	logic [2:0] cnt;
	logic [7:0] shreg;
	logic [7:0] rx_byte;
	logic last_bit;
	logic addr_hit;
	logic [7:0] rsh;
	logic [7:0] addr_hi;
	logic [ADDR_W-1:0] addr;
	logic drive_low;
	logic [7:0] mem [2**ADDR_W];

	// ************************************************************
	// start and stop detection
	// ************************************************************
	// data edges with the clock high act as their own clock here;
	// the bus setup time before the next clock fall settles these
	// toggles, so the falling-edge logic may read them directly
	always_ff @(negedge link.sda or negedge nrst) begin
		if (!nrst) begin
			start_tgl <= 1'b0;
		end else if (link.scl) begin
			start_tgl <= ~start_tgl;
		end
	end

	always_ff @(posedge link.sda or negedge nrst) begin
		if (!nrst) begin
			stop_tgl <= 1'b0;
		end else if (link.scl) begin
			stop_tgl <= ~stop_tgl;
		end
	end

	// acknowledge each seen condition on the falling edge
	always_ff @(negedge link.scl or negedge nrst) begin
		if (!nrst) begin
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
		end else begin
			start_seen <= start_tgl;
			stop_seen <= stop_tgl;
		end
	end

	assign start_ev = start_tgl != start_seen;
	assign stop_ev = stop_tgl != stop_seen;

	// ************************************************************
	// input sampling
	// ************************************************************
	// data bit taken on the rising clock edge only
	always_ff @(posedge link.scl or negedge nrst) begin
		if (!nrst) begin
			sda_smp <= 1'b1;
		end else begin
			sda_smp <= link.sda;
		end
	end

	// static pins pass two flops; master keeps protect steady
	always_ff @(posedge link.scl or negedge nrst) begin
		if (!nrst) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= {write_protect, chip_select_pins};
			pin_sync <= pin_meta;
		end
	end

	assign wp = pin_sync[3];
	assign sel = pin_sync[2:0];

	// ************************************************************
	// byte decode
	// ************************************************************
	assign rx_byte = {shreg[6:0], sda_smp};
	assign last_bit = cnt == snv_pkg::LAST_BIT;
	assign addr_hit = rx_byte[7:snv_pkg::SEL_LSB] == {DEV_TYPE, sel};

	// ************************************************************
	// protocol state machine
	// ************************************************************
	// next state; start outranks stop when both fell in one high phase
	always_comb begin
		next_state = state;
		next_ret_state = ret_state;
		if (start_ev) begin
			next_state = snv_pkg::st_addr;
		end else if (stop_ev) begin
			next_state = snv_pkg::st_idle;
		end else begin
			unique case (state)
				snv_pkg::st_idle: begin
					next_state = snv_pkg::st_idle;
				end
				snv_pkg::st_addr: begin
					if (last_bit) begin
						// a matching address is always answered: there is no busy time
						next_state = addr_hit ? snv_pkg::st_ack : snv_pkg::st_idle;
						next_ret_state = rx_byte[snv_pkg::DIR_BIT] ? snv_pkg::st_rdata
							: snv_pkg::st_mhi;
					end
				end
				snv_pkg::st_ack: begin
					next_state = ret_state;
				end
				snv_pkg::st_mhi: begin
					if (last_bit) begin
						next_state = snv_pkg::st_ack;
						next_ret_state = snv_pkg::st_mlo;
					end
				end
				snv_pkg::st_mlo: begin
					if (last_bit) begin
						next_state = snv_pkg::st_ack;
						next_ret_state = snv_pkg::st_wdata;
					end
				end
				snv_pkg::st_wdata: begin
					if (last_bit) begin
						// protected bytes get no ack: the write ends
						next_state = wp ? snv_pkg::st_idle : snv_pkg::st_ack;
						next_ret_state = snv_pkg::st_wdata;
					end
				end
				snv_pkg::st_rdata: begin
					if (last_bit) begin
						next_state = snv_pkg::st_rack;
					end
				end
				snv_pkg::st_rack: begin
					// high on the ninth bit is a no-acknowledge
					next_state = sda_smp ? snv_pkg::st_idle : snv_pkg::st_rdata;
				end
			endcase
		end
	end

	// state, return point and bit counter move on the falling edge
	always_ff @(negedge link.scl or negedge nrst) begin
		if (!nrst) begin
			state <= snv_pkg::st_idle;
			ret_state <= snv_pkg::st_idle;
			cnt <= 3'h0;
			shreg <= 8'h00;
		end else begin
			state <= next_state;
			ret_state <= next_ret_state;
			cnt <= (start_ev || next_state != state) ? 3'h0 : cnt + 3'h1;
			shreg <= rx_byte;
		end
	end

	// ************************************************************
	// address latch
	// ************************************************************
	// kept until rewritten; no reset other than power-on
	always_ff @(negedge link.scl or negedge nrst) begin
		if (!nrst) begin
			addr_hi <= 8'h00;
			addr <= snv_pkg::ADDR_RESET;
		end else if (!start_ev && !stop_ev && last_bit) begin
			unique case (state)
				snv_pkg::st_mhi: begin
					addr_hi <= rx_byte;
				end
				snv_pkg::st_mlo: begin
					// top bit of the high byte is ignored
					addr <= {addr_hi[snv_pkg::ADDR_HI_USED-1:0], rx_byte};
				end
				snv_pkg::st_wdata: begin
					if (!wp) begin
						addr <= ADDR_W'(addr + 1);
					end
				end
				snv_pkg::st_rdata: begin
					addr <= ADDR_W'(addr + 1);
				end
				default: begin
					addr <= addr;
				end
			endcase
		end
	end

	// ************************************************************
	// byte array
	// ************************************************************
	// committed on the fall after bit eight, before the ack slot;
	// an abort earlier leaves the array untouched
	always_ff @(negedge link.scl) begin
		if (!start_ev && !stop_ev && state == snv_pkg::st_wdata && last_bit && !wp) begin
			mem[addr] <= rx_byte;
		end
	end

	// ************************************************************
	// read shifter and line driver
	// ************************************************************
	// loaded from the current address on entry to a read byte
	always_ff @(negedge link.scl or negedge nrst) begin
		if (!nrst) begin
			rsh <= 8'h00;
		end else if (next_state == snv_pkg::st_rdata) begin
			rsh <= (state != snv_pkg::st_rdata) ? mem[addr] : {rsh[6:0], 1'b0};
		end
	end

	// line changes only on the falling edge
	always_ff @(negedge link.scl or negedge nrst) begin
		if (!nrst) begin
			drive_low <= 1'b0;
		end else begin
			unique case (next_state)
				snv_pkg::st_ack: begin
					drive_low <= 1'b1;
				end
				snv_pkg::st_rdata: begin
					// first bit on the clock right after the ack slot
					drive_low <= (state != snv_pkg::st_rdata) ? ~mem[addr][7] : ~rsh[6];
				end
				default: begin
					drive_low <= 1'b0;
				end
			endcase
		end
	end

	// open drain: only ever pulls low
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe = drive_low;

endmodule // snv_slave

/* File: core/snv_master.sv */
// bus master end of the two-wire link: byte-level command engine
`timescale 1ns/1ns
module snv_master #(
	parameter int QTR = snv_pkg::QTR_CYC
) (
	// system clock and reset
	input wire logic clk,
	input wire logic nrst,
	// two-wire link
	snv_link_if.master link,
	// command port
	input wire logic req_valid,
	output logic req_ready,
	input wire snv_pkg::snv_op_t req_op,
	input wire logic [7:0] req_data,
	input wire logic req_ack,
	// answer port
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack
);

	// ************************************************************
	// declarations
	// ************************************************************
	localparam int QW = $clog2(QTR + 1);
	snv_pkg::snv_mst_state_t state;
	snv_pkg::snv_op_t op;
	logic [QW-1:0] qcnt;
	logic tick;
	logic [1:0] ph;
	logic [3:0] bitn;
	logic [7:0] sh;
	logic ack_en;
	logic nack;
	logic sda_meta;
	logic sda_s;
	logic scl;
	logic sda_oe;
	logic finish;
	logic is_byte;

	// ************************************************************
	// quarter-phase divider and line sampling
	// ************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			qcnt <= '0;
		end else begin
			qcnt <= tick ? '0 : qcnt + 1'b1;
		end
	end

	assign tick = qcnt == QW'(QTR - 1);

	// data line comes from the other domain: two flops first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sda_meta <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_meta <= link.sda;
			sda_s <= sda_meta;
		end
	end

	assign is_byte = op == snv_pkg::op_write || op == snv_pkg::op_read;
	assign finish = state == snv_pkg::mst_run && tick && ph == 2'h3
		&& (!is_byte || bitn == snv_pkg::ACK_SLOT);

	// ************************************************************
	// bit sequencer
	// ************************************************************
	// each bit: set data, raise clock, sample, drop clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= snv_pkg::mst_idle;
			op <= snv_pkg::op_stop;
			ph <= 2'h0;
			bitn <= 4'h0;
			sh <= 8'h00;
			ack_en <= 1'b0;
			nack <= 1'b1;
			scl <= 1'b1;
			sda_oe <= 1'b0;
			req_ready <= 1'b1;
		end else if (state == snv_pkg::mst_idle) begin
			if (req_valid) begin
				state <= snv_pkg::mst_run;
				op <= req_op;
				sh <= req_data;
				ack_en <= req_ack;
				ph <= 2'h0;
				bitn <= 4'h0;
				req_ready <= 1'b0;
			end
		end else if (tick) begin
			ph <= ph + 2'h1;
			unique case (ph)
				2'h0: begin
					unique case (op)
						snv_pkg::op_start: sda_oe <= 1'b0;
						snv_pkg::op_stop: sda_oe <= 1'b1;
						// msb first, released in the ack slot
						snv_pkg::op_write: sda_oe <= bitn != snv_pkg::ACK_SLOT && !sh[7];
						snv_pkg::op_read: sda_oe <= bitn == snv_pkg::ACK_SLOT && ack_en;
					endcase
				end
				2'h1: begin
					scl <= 1'b1;
				end
				2'h2: begin
					// with the clock high only start and stop move data
					if (op == snv_pkg::op_start) begin
						sda_oe <= 1'b1;
					end else if (op == snv_pkg::op_stop) begin
						sda_oe <= 1'b0;
					end else if (bitn == snv_pkg::ACK_SLOT) begin
						nack <= sda_s;
					end else begin
						sh <= {sh[6:0], sda_s};
					end
				end
				2'h3: begin
					// a stop leaves the clock high for bus idle
					scl <= op == snv_pkg::op_stop;
					bitn <= bitn + 4'h1;
					if (finish) begin
						state <= snv_pkg::mst_idle;
						req_ready <= 1'b1;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// answer
	// ************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_nack <= 1'b0;
		end else begin
			rsp_valid <= finish;
			if (finish) begin
				rsp_data <= sh;
				rsp_nack <= is_byte ? nack : 1'b0;
			end
		end
	end

	assign link.scl = scl;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe = sda_oe;

endmodule // snv_master

/* File: tb/snv_link_sva.sv */
// concurrent checks on the two-wire link between master and memory slave
`timescale 1ns/1ns
module snv_link_sva #(
	parameter logic [3:0] DEV_TYPE = snv_pkg::DEV_TYPE,
	parameter logic [2:0] SEL = 3'h0
) (
	// sampling clock and reset
	input wire logic clk,
	input wire logic nrst,
	// link signals
	input wire logic scl,
	input wire logic m_sda_o,
	input wire logic m_sda_oe,
	input wire logic s_sda_o,
	input wire logic s_sda_oe,
	input wire logic sda
);
	// ************************************************************
	// frame tracking helpers
	// ************************************************************
	logic scl_q, sda_q, in_frame, sel, rd, quiet;
	logic [3:0] bitn;
	logic [1:0] nbyte;
	logic [7:0] shift;
	logic rise, start, stop, match;
	// conditions seen at the system clock; quarters keep them apart
	assign rise = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop = scl & scl_q & ~sda_q & sda;
	assign match = (shift[7:4] == DEV_TYPE) && (shift[3:1] == SEL);

	// previous line levels
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// bit slot, byte count and addressed direction
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_frame <= 1'b0;
			bitn <= 4'h0;
			nbyte <= 2'h0;
			shift <= 8'h00;
			sel <= 1'b0;
			rd <= 1'b0;
			quiet <= 1'b0;
		end else if (start) begin
			in_frame <= 1'b1;
			bitn <= 4'h0;
			nbyte <= 2'h0;
			rd <= 1'b0;
			quiet <= 1'b0;
		end else if (stop) begin
			in_frame <= 1'b0;
		end else if (rise && in_frame) begin
			if (bitn == 4'h8) begin
				bitn <= 4'h0;
				nbyte <= (nbyte == 2'h3) ? nbyte : nbyte + 2'h1;
				if (nbyte == 2'h0) begin
					sel <= match;
					rd <= match & shift[0];
				end
				// no further slave drive after a refused address or a read nack
				if ((nbyte == 2'h0 && !match) || (rd && sda))
					quiet <= 1'b1;
			end else begin
				bitn <= bitn + 4'h1;
				shift <= {shift[6:0], sda};
			end
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_slave_fall_only: assert property ($changed(s_sda_oe) |-> $fell(scl))
		else $error("slave data moved away from a clock fall");
	a_cond_owns_line: assert property ($changed(m_sda_oe) && scl && scl_q |-> !s_sda_oe)
		else $error("start or stop while slave drives data");
	a_addr_quiet: assert property (in_frame && nbyte == 2'h0 && bitn >= 4'h1 && bitn <= 4'h7 |-> !s_sda_oe)
		else $error("slave drives during address byte");
	a_addr_ack: assert property (rise && in_frame && bitn == 4'h8 && nbyte == 2'h0 |-> sda == !match)
		else $error("address acknowledge does not follow match");
	a_maddr_ack: assert property (rise && in_frame && bitn == 4'h8 && nbyte inside {2'h1, 2'h2} && sel && !rd
		|-> !sda)
		else $error("memory address byte not acknowledged");
	a_read_release: assert property (rise && bitn == 4'h8 && rd && nbyte != 2'h0 |-> !s_sda_oe)
		else $error("slave holds data in read acknowledge slot");
	a_quiet_after: assert property (quiet |-> !s_sda_oe)
		else $error("slave drives after nack or mismatch");
	a_idle_quiet: assert property (!in_frame |-> !s_sda_oe)
		else $error("slave drives outside a frame");
	a_ack_one_slot: assert property ($rose(s_sda_oe) && nbyte != 2'h0 && !rd
		|=> s_sda_oe [*4] ##[1:40] !s_sda_oe)
		else $error("write acknowledge not one slot long");

	cover property (rise && rd && bitn == 4'h8 && sda);
	cover property (rise && bitn == 4'h8 && nbyte == 2'h0 && !match);
	cover property (start && in_frame);
endmodule // snv_link_sva

/* File: tb/snv_link_bench.sv */
// self-checking bench: master and memory slave joined across the link
`timescale 1ns/1ns
module snv_link_bench;
	localparam logic [2:0] SEL = 3'h5;
	localparam logic [7:0] ADR_W = {snv_pkg::DEV_TYPE, SEL, 1'b0};
	localparam logic [7:0] ADR_R = {snv_pkg::DEV_TYPE, SEL, 1'b1};
	localparam logic [7:0] BAD_SEL = {snv_pkg::DEV_TYPE, ~SEL, 1'b0};
	localparam logic [7:0] BAD_TYPE = {~snv_pkg::DEV_TYPE, SEL, 1'b0};
	logic clk = 1'b0;
	logic nrst = 1'b1;
	logic write_protect = 1'b0;
	logic req_valid = 1'b0;
	snv_pkg::snv_op_t req_op = snv_pkg::op_start;
	logic [7:0] req_data = 8'h00;
	logic req_ack = 1'b0;
	logic req_ready, rsp_valid, rsp_nack;
	logic [7:0] rsp_data;
	int err_count = 0;
	int total_checks = 0;

	// ************************************************************
	// ends, link and checker
	// ************************************************************
	snv_link_if link ();
	// short quarters keep the run brief; scl period is 16 clocks
	snv_master #(.QTR(4)) u_snv_master (.clk(clk), .nrst(nrst), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_data(req_data), .req_ack(req_ack),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
	snv_slave u_snv_slave (.nrst(nrst), .link(link), .chip_select_pins(SEL), .write_protect(write_protect));
	snv_link_sva #(.SEL(SEL)) u_snv_link_sva (.clk(clk), .nrst(nrst), .scl(link.scl), .m_sda_o(link.m_sda_o),
		.m_sda_oe(link.m_sda_oe), .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .sda(link.sda));

	always #10 clk = ~clk;

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one command; a request not taken also ends in the timeout
	task automatic xfer(input snv_pkg::snv_op_t op, input logic [7:0] data, input logic ack);
		int n;
		@(posedge clk);
		req_op <= op;
		req_data <= data;
		req_ack <= ack;
		req_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		if (req_ready !== 1'b1) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, req_ready, 1'b1);
			conclude();
		end
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 2000);
		if (rsp_valid !== 1'b1) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, rsp_valid, 1'b1);
			conclude();
		end
	endtask

	task automatic cond(input snv_pkg::snv_op_t op);
		xfer(op, 8'h00, 1'b0);
	endtask

	task automatic wr(input logic [7:0] b, input logic exp_nack);
		xfer(snv_pkg::op_write, b, 1'b0);
		check8({7'h00, rsp_nack}, {7'h00, exp_nack});
	endtask

	task automatic rd(input logic ack, input logic [7:0] exp);
		xfer(snv_pkg::op_read, 8'hFF, ack);
		check8(rsp_data, exp);
	endtask

	// start, write address byte, memory address high then low
	task automatic seladdr(input logic [7:0] hi, input logic [7:0] lo);
		cond(snv_pkg::op_start);
		wr(ADR_W, 1'b0);
		wr(hi, 1'b0);
		wr(lo, 1'b0);
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		// a declaration value makes no edge: this fall wakes the async resets
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		// write three bytes with the ignored top bit set, read back
		seladdr(8'hF2, 8'h34);
		wr(8'hA5, 1'b0);
		wr(8'h3C, 1'b0);
		wr(8'h96, 1'b0);
		cond(snv_pkg::op_stop);
		seladdr(8'h72, 8'h34);
		cond(snv_pkg::op_start);
		wr(ADR_R, 1'b0);
		rd(1'b1, 8'hA5);
		rd(1'b0, 8'h3C);
		cond(snv_pkg::op_start);
		wr(ADR_R, 1'b0);
		rd(1'b0, 8'h96);
		cond(snv_pkg::op_stop);
		$display("test write_and_read done");
		// top address rolls over to zero in write and read
		seladdr(8'h7F, 8'hFF);
		wr(8'h11, 1'b0);
		wr(8'h22, 1'b0);
		cond(snv_pkg::op_stop);
		seladdr(8'h7F, 8'hFF);
		cond(snv_pkg::op_start);
		wr(ADR_R, 1'b0);
		rd(1'b1, 8'h11);
		rd(1'b0, 8'h22);
		cond(snv_pkg::op_stop);
		$display("test wrap done");
		// wrong select bits, then wrong type nibble
		cond(snv_pkg::op_start);
		wr(BAD_SEL, 1'b1);
		cond(snv_pkg::op_start);
		wr(BAD_TYPE, 1'b1);
		cond(snv_pkg::op_stop);
		$display("test address_mismatch done");
		// protected write: refused, no store, latch unmoved
		seladdr(8'h00, 8'h10);
		wr(8'h5A, 1'b0);
		cond(snv_pkg::op_stop);
		write_protect <= 1'b1;
		seladdr(8'h00, 8'h10);
		wr(8'h77, 1'b1);
		cond(snv_pkg::op_stop);
		write_protect <= 1'b0;
		cond(snv_pkg::op_start);
		wr(ADR_R, 1'b0);
		rd(1'b0, 8'h5A);
		cond(snv_pkg::op_stop);
		$display("test write_protect done");
		// second reset: latch back to zero, array kept
		nrst <= 1'b0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		cond(snv_pkg::op_start);
		wr(ADR_R, 1'b0);
		rd(1'b0, 8'h22);
		cond(snv_pkg::op_stop);
		$display("test reset_latch done");
		conclude();
	end
endmodule // snv_link_bench
